// ### src/debug_ctl_regs.svh
// constants for the single-pin debug mode controller
`ifndef DEBUG_CTL_REGS_SVH
`define DEBUG_CTL_REGS_SVH

`define AUTOBAUD_CHAR      8'h80
`define KEY_BYTE0          8'heb
`define KEY_BYTE1          8'h5a
`define KEY_BYTE2          8'h70
`define KEY_BYTE3          8'hcd
`define DATA_BITS          4'h8
`define BAUD_MIN_DIV       16'h0004
`define BAUD_MAX_DIV       16'h0200
`define BAUD_DIV_W         16
`define BREAK_SHIFT        3
`define COUNT_ZERO         16'h0000
`define COUNT_ONE          16'h0001

`endif

// ### src/debug_ctl_pkg.sv
// types for the single-pin debug mode controller
`default_nettype none
package debug_ctl_pkg;
	typedef enum logic [2:0] {
		LINK_BAUD  = 3'b000,
		LINK_IDLE  = 3'b001,
		LINK_RX    = 3'b011,
		LINK_TX    = 3'b010,
		LINK_BREAK = 3'b110
	} link_state_t;

	typedef enum logic [2:0] {
		KEY_SYNC  = 3'b000,
		KEY_B0    = 3'b001,
		KEY_B1    = 3'b011,
		KEY_B2    = 3'b010,
		KEY_B3    = 3'b110,
		KEY_OPEN  = 3'b111
	} key_state_t;
endpackage
`default_nettype wire

// ### src/debug_bit_timer.sv
// bit-period enable generator for the serial link
`default_nettype none
`include "debug_ctl_regs.svh"
module debug_bit_timer #(
	parameter int DIV_W = `BAUD_DIV_W
) (
	// clock and restart
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             restart,
	// period in cycles
	input  wire logic [DIV_W-1:0] period,
	// enables
	output logic                  half_tick,
	output logic                  bit_tick
);
	// the longest bit period must fit the counter
	if (DIV_W < $clog2(`BAUD_MAX_DIV) + 1) begin : g_div_check
		$error("divider too narrow");
	end

	localparam logic [DIV_W-1:0] CNT_ONE = DIV_W'(`COUNT_ONE);

	logic [DIV_W-1:0] cnt_q;
	wire              at_end  = (cnt_q >= period - CNT_ONE);
	wire  [DIV_W-1:0] half_pt = period >> 1;

	always_ff @(posedge clk_sys) begin
		if (rst || restart || at_end) cnt_q <= '0;
		else cnt_q <= cnt_q + CNT_ONE;
	end

	assign bit_tick  = at_end && !restart;
	assign half_tick = (cnt_q == half_pt) && !restart;
endmodule // debug_bit_timer
`default_nettype wire

// ### src/debug_key_check.sv
// unlock key matcher for the shared-pin variant
`default_nettype none
`include "debug_ctl_regs.svh"
module debug_key_check (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// received characters
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	input  wire logic       reset_pin_low,
	// result
	output logic            unlocked
);
	debug_ctl_pkg::key_state_t st_q;
	debug_ctl_pkg::key_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (!reset_pin_low) begin
			if (st_q != debug_ctl_pkg::KEY_OPEN) st_d = debug_ctl_pkg::KEY_SYNC;
		end else if (byte_valid) begin
			case (st_q)
				debug_ctl_pkg::KEY_SYNC: st_d = (byte_data == `AUTOBAUD_CHAR) ?
					debug_ctl_pkg::KEY_B0 : debug_ctl_pkg::KEY_SYNC;
				debug_ctl_pkg::KEY_B0: st_d = (byte_data == `KEY_BYTE0) ?
					debug_ctl_pkg::KEY_B1 : debug_ctl_pkg::KEY_SYNC;
				debug_ctl_pkg::KEY_B1: st_d = (byte_data == `KEY_BYTE1) ?
					debug_ctl_pkg::KEY_B2 : debug_ctl_pkg::KEY_SYNC;
				debug_ctl_pkg::KEY_B2: st_d = (byte_data == `KEY_BYTE2) ?
					debug_ctl_pkg::KEY_B3 : debug_ctl_pkg::KEY_SYNC;
				debug_ctl_pkg::KEY_B3: st_d = (byte_data == `KEY_BYTE3) ?
					debug_ctl_pkg::KEY_OPEN : debug_ctl_pkg::KEY_SYNC;
				debug_ctl_pkg::KEY_OPEN: st_d = debug_ctl_pkg::KEY_OPEN;
				default: st_d = debug_ctl_pkg::KEY_SYNC;
			endcase
		end
	end

	// power-on style reset only: unlock survives pin resets
	always_ff @(posedge clk_sys) begin
		if (rst) st_q <= debug_ctl_pkg::KEY_SYNC;
		else st_q <= st_d;
	end

	assign unlocked = (st_q == debug_ctl_pkg::KEY_OPEN);
endmodule // debug_key_check
`default_nettype wire

// ### src/debug_mode_ctl.sv
// single-pin debug link and debug mode controller
//
// Contract
// - one open-drain line carries all debug traffic, device only pulls low.
// - half duplex; device never receives while it transmits.
// - asynchronous start/stop characters, line idles high.
// - one start bit, eight data bits lsb first, one stop bit.
// - debug mode stops instruction fetch except directed instructions.
// - debug mode keeps the system clock running unless in deep sleep.
// - debug mode keeps enabled peripherals running unless in deep sleep.
// - entering debug mode leaves the idle state.
// - debug mode refreshes an enabled watchdog continuously.
// - breakpoint opcode execution enters debug mode.
// - line low in the last reset cycle enters debug mode after reset.
// - shared pin unlocks only by a 32-bit key sent under reset.
// - without unlock the shared pin stays general-purpose i/o except while the reset pin is held low.
// - writing zero to the debug mode bit leaves debug mode.
// - power-on, brownout, watchdog or pin reset leaves debug mode.
// - line low in deep sleep starts a system reset, ending debug mode.
`default_nettype none
`include "debug_ctl_regs.svh"
module debug_mode_ctl #(
	parameter int  DIV_W       = `BAUD_DIV_W,
	parameter bit  SHARED_PIN  = 1'b0
) (
	// clock and resets
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       sys_reset_active,
	input  wire logic       por_reset,
	input  wire logic       brownout_reset,
	input  wire logic       watchdog_reset,
	input  wire logic       reset_pin_low,
	// debug line, open drain
	input  wire logic       debug_line_in,
	output logic            debug_line_out,
	output logic            debug_line_oe,
	// processor side
	input  wire logic       breakpoint_opcode,
	input  wire logic       break_enable,
	input  wire logic       mode_bit_write,
	input  wire logic       mode_bit_wdata,
	input  wire logic       directed_exec,
	input  wire logic       deep_sleep_state,
	input  wire logic       idle_state,
	input  wire logic       watchdog_enable,
	// debugger traffic
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	// status and control outputs
	output logic            debug_mode_bit,
	output logic            fetch_enable,
	output logic            idle_exit,
	output logic            clock_keep,
	output logic            periph_keep,
	output logic            watchdog_refresh,
	output logic            sleep_wake_reset,
	output logic            baud_locked,
	output logic            debug_pin_enabled
);
	// eight periods of the slowest rate are measured, so the counter needs the room
	if (DIV_W < $clog2(`BAUD_MAX_DIV) + `BREAK_SHIFT + 1) begin : g_div_check
		$error("divider width too small for 512 cycles per bit");
	end

	localparam logic [DIV_W-1:0] CNT_ZERO = DIV_W'(`COUNT_ZERO);
	localparam logic [DIV_W-1:0] CNT_ONE  = DIV_W'(`COUNT_ONE);

	function automatic logic rst_any(input logic a, input logic b, input logic c,
		input logic d);
		rst_any = a | b | c | d;
	endfunction

	// pin gating and line view
	logic pin_en_q;
	wire  hard_reset = rst_any(por_reset, brownout_reset, watchdog_reset, reset_pin_low);
	wire  line_rx    = pin_en_q ? debug_line_in : 1'b1;

	// link state
	debug_ctl_pkg::link_state_t st_q;
	logic [DIV_W-1:0] period_q;
	logic [DIV_W-1:0] low_cnt_q;
	logic [3:0]       bit_q;
	logic [8:0]       sh_q;
	logic             tx_drv_q;
	logic             rx_v_q;
	logic [7:0]       rx_d_q;
	logic             prev_q;
	logic [1:0]       brk_chars_q;

	// state decodes
	wire in_idle    = (st_q == debug_ctl_pkg::LINK_IDLE);
	wire in_rx      = (st_q == debug_ctl_pkg::LINK_RX);
	wire in_tx      = (st_q == debug_ctl_pkg::LINK_TX);
	wire in_brk     = (st_q == debug_ctl_pkg::LINK_BREAK);
	wire in_frame   = in_rx || in_tx;
	// the bit timer only runs inside a frame or a break
	wire restart    = !in_frame && !in_brk;
	wire half_tick;
	wire bit_tick;

	debug_bit_timer #(
		.DIV_W (DIV_W)
	) u_timer (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.restart   (restart),
		.period    (period_q),
		.half_tick (half_tick),
		.bit_tick  (bit_tick)
	);

	// start edge, low-time measurement and break
	wire fall        = prev_q && !line_rx;
	wire rise        = !prev_q && line_rx;
	wire low_sat     = (low_cnt_q == {DIV_W{1'b1}});
	wire [DIV_W-1:0] baud_meas = low_cnt_q >> `BREAK_SHIFT;
	wire meas_ok     = (baud_meas >= DIV_W'(`BAUD_MIN_DIV))
		&& (baud_meas <= DIV_W'(`BAUD_MAX_DIV));
	wire brk_seen    = baud_locked && !line_rx && (low_cnt_q > (period_q << `BREAK_SHIFT));
	wire rx_sample   = in_rx && half_tick;
	wire rx_last     = rx_sample && (bit_q == `DATA_BITS + 4'h1);
	wire rx_good     = rx_last && line_rx;
	wire tx_last     = in_tx && bit_tick && (bit_q == `DATA_BITS + 4'h1);
	// collision: we release high, line reads low mid-bit
	wire collide     = in_tx && half_tick && tx_drv_q && !line_rx;

	always_ff @(posedge clk_sys) begin
		if (rst || sys_reset_active) prev_q <= 1'b1;
		else prev_q <= line_rx;
		if (rst || sys_reset_active || line_rx) low_cnt_q <= CNT_ZERO;
		else if (!low_sat) low_cnt_q <= low_cnt_q + CNT_ONE;
	end

	always_ff @(posedge clk_sys) begin
		rx_v_q <= 1'b0;
		if (rst || sys_reset_active) begin
			st_q        <= debug_ctl_pkg::LINK_BAUD;
			period_q    <= DIV_W'(`BAUD_MAX_DIV);
			baud_locked <= 1'b0;
			tx_drv_q    <= 1'b1;
			bit_q       <= 4'h0;
			sh_q        <= 9'h1ff;
			rx_d_q      <= 8'h00;
			brk_chars_q <= 2'b00;
		end else begin
			case (st_q)
				// 80H: start plus seven zero bits low, eight periods
				debug_ctl_pkg::LINK_BAUD: if (rise && meas_ok) begin
					period_q    <= baud_meas;
					baud_locked <= 1'b1;
					st_q        <= debug_ctl_pkg::LINK_IDLE;
				end
				debug_ctl_pkg::LINK_IDLE: if (brk_seen) begin
					st_q <= debug_ctl_pkg::LINK_BREAK;
				end else if (fall) begin
					st_q  <= debug_ctl_pkg::LINK_RX;
					bit_q <= 4'h0;
				end else if (tx_valid) begin
					// start bit goes out on the edge that takes the request
					tx_drv_q <= 1'b0;
					sh_q     <= {tx_data, 1'b0};
					bit_q    <= 4'h0;
					st_q     <= debug_ctl_pkg::LINK_TX;
				end
				debug_ctl_pkg::LINK_RX: if (rx_sample) begin
					bit_q <= bit_q + 4'h1;
					if (bit_q == 4'h0 && line_rx) st_q <= debug_ctl_pkg::LINK_IDLE;
					else if (bit_q != 4'h0 && bit_q <= `DATA_BITS)
						rx_d_q <= {line_rx, rx_d_q[7:1]};
					if (rx_good) begin
						rx_v_q <= 1'b1;
						st_q   <= debug_ctl_pkg::LINK_IDLE;
					end else if (rx_last) begin
						st_q        <= debug_ctl_pkg::LINK_BREAK;
						brk_chars_q <= 2'b00;
					end
				end
				debug_ctl_pkg::LINK_TX: if (collide) begin
					tx_drv_q    <= 1'b1;
					st_q        <= debug_ctl_pkg::LINK_BREAK;
					brk_chars_q <= 2'b00;
				end else if (bit_tick) begin
					// bit number bit_q has ended: put out the next one, stop after data
					tx_drv_q <= (bit_q >= `DATA_BITS) ? 1'b1 : sh_q[1];
					sh_q     <= {1'b1, sh_q[8:1]};
					bit_q    <= bit_q + 4'h1;
					if (tx_last) st_q <= debug_ctl_pkg::LINK_IDLE;
				end else if (bit_q == 4'h0) begin
					tx_drv_q <= sh_q[0];
				end
				// answer a break with our own, then wait for release and re-baud
				debug_ctl_pkg::LINK_BREAK: begin
					if (bit_tick && bit_q != 4'hf) bit_q <= bit_q + 4'h1;
					if (bit_tick && bit_q == 4'h9 && brk_chars_q != 2'b11) begin
						brk_chars_q <= brk_chars_q + 2'b01;
						bit_q       <= 4'h0;
					end
					tx_drv_q <= (bit_q == 4'hf);
					if (bit_q == 4'hf && line_rx) begin
						baud_locked <= 1'b0;
						st_q        <= debug_ctl_pkg::LINK_BAUD;
					end
					if (bit_tick && bit_q == 4'h9 && brk_chars_q == 2'b11) bit_q <= 4'hf;
				end
				default: st_q <= debug_ctl_pkg::LINK_BAUD;
			endcase
		end
	end

	assign tx_ready = in_idle && !fall && !brk_seen;
	assign rx_valid = rx_v_q;
	assign rx_data  = rx_d_q;
	assign debug_line_out = 1'b0;
	assign debug_line_oe  = !tx_drv_q && pin_en_q;

	// shared-pin unlock
	wire key_open;

	debug_key_check u_key (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.byte_valid    (rx_v_q),
		.byte_data     (rx_d_q),
		.reset_pin_low (reset_pin_low),
		.unlocked      (key_open)
	);

	// key bytes arrive while the pin-reset is held, so listen then too
	always_ff @(posedge clk_sys) begin
		if (rst) pin_en_q <= !SHARED_PIN;
		else pin_en_q <= !SHARED_PIN || key_open || reset_pin_low;
	end

	// debug mode
	logic mode_q;
	logic last_rst_low_q;
	logic reset_was_q;
	logic wake_q;
	// our own start or break bits must not look like the host pulling low
	wire  line_low_raw = pin_en_q && tx_drv_q && !debug_line_in;
	wire  rst_release  = reset_was_q && !sys_reset_active;
	wire  bp_enter     = breakpoint_opcode && break_enable && !mode_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_q         <= 1'b0;
			last_rst_low_q <= 1'b0;
			reset_was_q    <= 1'b0;
			wake_q         <= 1'b0;
		end else begin
			reset_was_q <= sys_reset_active;
			if (sys_reset_active) last_rst_low_q <= line_low_raw;
			wake_q <= deep_sleep_state && line_low_raw;
			// exit outranks entry, and entry outranks a plain write
			if (hard_reset || wake_q) mode_q <= 1'b0;
			else if (rst_release && last_rst_low_q) mode_q <= 1'b1;
			else if (bp_enter) mode_q <= 1'b1;
			else if (mode_bit_write) mode_q <= mode_bit_wdata;
		end
	end

	// next values of the status outputs
	wire fetch_enable_d     = (!mode_q || directed_exec) && !sys_reset_active;
	wire idle_exit_d        = mode_q && idle_state;
	wire keep_d             = mode_q && !deep_sleep_state;
	wire watchdog_refresh_d = mode_q && watchdog_enable;

	// processor-facing status
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			debug_mode_bit <= 1'b0;
			fetch_enable   <= 1'b0;
			idle_exit      <= 1'b0;
		end else begin
			debug_mode_bit <= mode_q;
			fetch_enable   <= fetch_enable_d;
			idle_exit      <= idle_exit_d;
		end
	end

	// system-facing status
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clock_keep        <= 1'b0;
			periph_keep       <= 1'b0;
			watchdog_refresh  <= 1'b0;
			sleep_wake_reset  <= 1'b0;
			debug_pin_enabled <= 1'b0;
		end else begin
			clock_keep        <= keep_d;
			periph_keep       <= keep_d;
			watchdog_refresh  <= watchdog_refresh_d;
			sleep_wake_reset  <= wake_q;
			debug_pin_enabled <= pin_en_q;
		end
	end
endmodule // debug_mode_ctl
`default_nettype wire

// ### bench/debug_mode_ctl_monitor.sv
// port assertions for the debug mode controller
`default_nettype none
module debug_mode_ctl_monitor (
	// clock and resets
	input wire logic clk_sys, rst, sys_reset_active,
	input wire logic por_reset, brownout_reset, watchdog_reset, reset_pin_low,
	// debug line
	input wire logic debug_line_in, debug_line_out, debug_line_oe,
	// processor side
	input wire logic breakpoint_opcode, break_enable, mode_bit_write, mode_bit_wdata,
	input wire logic directed_exec, deep_sleep_state, idle_state, watchdog_enable,
	// traffic and status
	input wire logic tx_valid, tx_ready, rx_valid, debug_mode_bit, fetch_enable,
	input wire logic idle_exit, clock_keep, periph_keep, watchdog_refresh, sleep_wake_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic hard_rst = por_reset | brownout_reset | watchdog_reset | reset_pin_low;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_pull_only: assert property (debug_line_out == 1'b0)
		else $error("debug line driven high");
	a_no_rx_tx: assert property (debug_line_oe |-> !rx_valid)
		else $error("receive while transmitting");
	a_start_low: assert property (tx_valid && tx_ready |=> debug_line_oe)
		else $error("no start bit after transmit request");
	a_brk_enter: assert property (breakpoint_opcode && break_enable && !hard_rst
		&& !sys_reset_active && !deep_sleep_state |-> ##2 debug_mode_bit)
		else $error("breakpoint did not enter debug mode");
	a_hard_exit: assert property (hard_rst |-> ##2 !debug_mode_bit)
		else $error("reset did not leave debug mode");
	a_bit_clear: assert property (mode_bit_write && !mode_bit_wdata && !breakpoint_opcode
		&& !sys_reset_active |-> ##2 !debug_mode_bit)
		else $error("mode bit write did not leave debug mode");
	a_fetch_stop: assert property ((debug_mode_bit && !directed_exec)[*3] |-> !fetch_enable)
		else $error("fetch running in debug mode");
	a_keep_run: assert property ((debug_mode_bit && !deep_sleep_state)[*3]
		|-> clock_keep && periph_keep)
		else $error("clock or peripherals stopped in debug mode");
	a_wdog_kept: assert property ((debug_mode_bit && watchdog_enable)[*3] |-> watchdog_refresh)
		else $error("watchdog not refreshed");
	a_idle_leave: assert property ($rose(debug_mode_bit) && idle_state |-> ##[0:2] idle_exit)
		else $error("idle state not left");
	a_sleep_wake: assert property (debug_mode_bit && deep_sleep_state && !debug_line_in
		|-> ##2 sleep_wake_reset)
		else $error("no reset from line low in deep sleep");
endmodule // debug_mode_ctl_monitor
bind debug_mode_ctl debug_mode_ctl_monitor debug_mode_ctl_monitor_inst (.clk_sys, .rst,
	.sys_reset_active, .por_reset, .brownout_reset, .watchdog_reset, .reset_pin_low,
	.debug_line_in, .debug_line_out, .debug_line_oe, .breakpoint_opcode, .break_enable,
	.mode_bit_write, .mode_bit_wdata, .directed_exec, .deep_sleep_state, .idle_state,
	.watchdog_enable, .tx_valid, .tx_ready, .rx_valid, .debug_mode_bit, .fetch_enable,
	.idle_exit, .clock_keep, .periph_keep, .watchdog_refresh, .sleep_wake_reset);
`default_nettype wire

// ### bench/debug_host_model.sv
// behavioural debug host on the open-drain debug line
`default_nettype none
module debug_host_model #(
	parameter int PERIOD = 8
) (
	// clock and line
	input  wire logic clk_sys,
	input  wire logic line,
	// host pull-down
	output var logic  host_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_byte = 8'h00;
	int         rx_cnt  = 0;
	initial host_pull = 1'b0;
	// start low, lsb first, stop by release to the pull-up
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (line !== 1'b1) @(negedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			host_pull = !f[i];
			repeat (PERIOD) @(negedge clk_sys);
		end
	endtask
	task automatic hold_low(input int n);
		host_pull = 1'b1;
		repeat (n) @(negedge clk_sys);
		host_pull = 1'b0;
	endtask
	// unlock key, sent while the reset pin is held low
	task automatic send_unlock;
		send_byte(8'h80);
		send_byte(8'heb);
		send_byte(8'h5a);
		send_byte(8'h70);
		send_byte(8'hcd);
	endtask
	// receiver of device characters, samples mid bit
	always begin
		@(negedge line);
		if (!host_pull) begin
			repeat (PERIOD + PERIOD / 2) @(posedge clk_sys);
			for (int i = 0; i < 8; i++) begin
				rx_byte[i] = line;
				repeat (PERIOD) @(posedge clk_sys);
			end
			rx_cnt++;
		end
	end
endmodule // debug_host_model
`default_nettype wire

// ### bench/debug_mode_ctl_tb.sv
// self-checking bench for the debug mode controller
`default_nettype none
module debug_mode_ctl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 8;
	logic clk_sys = 1'b0, rst = 1'b1, sys_reset_active = 1'b0, por_reset = 1'b0;
	logic brownout_reset = 1'b0, watchdog_reset = 1'b0, reset_pin_low = 1'b0;
	logic breakpoint_opcode = 1'b0, break_enable = 1'b0, mode_bit_write = 1'b0;
	logic mode_bit_wdata = 1'b0, directed_exec = 1'b0, deep_sleep_state = 1'b0;
	logic idle_state = 1'b0, watchdog_enable = 1'b0, tx_valid = 1'b0, wake_seen = 1'b0;
	logic [7:0] tx_data = 8'h00, b;
	logic [31:0] seed = 32'h0001_6c99;
	wire logic debug_line_out, debug_line_oe, tx_ready, rx_valid, debug_mode_bit;
	wire logic fetch_enable, idle_exit, clock_keep, periph_keep, watchdog_refresh;
	wire logic sleep_wake_reset, baud_locked, debug_pin_enabled, host_pull;
	wire logic [7:0] rx_data;
	wire logic line = !((debug_line_oe && !debug_line_out) || host_pull);
	int error_cnt = 0, comparisons = 0, cycles = 0, n, rx_pulses = 0;
	debug_mode_ctl debug_mode_ctl_inst (.clk_sys, .rst, .sys_reset_active, .por_reset,
		.brownout_reset, .watchdog_reset, .reset_pin_low, .debug_line_in(line),
		.debug_line_out, .debug_line_oe, .breakpoint_opcode, .break_enable, .mode_bit_write,
		.mode_bit_wdata, .directed_exec, .deep_sleep_state, .idle_state, .watchdog_enable,
		.tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .debug_mode_bit, .fetch_enable,
		.idle_exit, .clock_keep, .periph_keep, .watchdog_refresh, .sleep_wake_reset,
		.baud_locked, .debug_pin_enabled);
	debug_host_model #(.PERIOD(P)) host (.clk_sys, .line, .host_pull);
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (sleep_wake_reset === 1'b1) wake_seen <= 1'b1;
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	always @(negedge clk_sys) begin
		if (rx_valid === 1'b1) rx_pulses++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		check(debug_mode_bit, 1'b0);
		check(debug_line_oe, 1'b0);
		check(debug_pin_enabled, 1'b1);
		// line held low across the end of system reset and long after
		fork
			host.hold_low(5020);
			begin
				sys_reset_active = 1'b1;
				repeat (10) @(negedge clk_sys);
				sys_reset_active = 1'b0;
			end
		join
		check(debug_mode_bit, 1'b1);
		check(fetch_enable, 1'b0);
		check(baud_locked, 1'b0);
		host.send_byte(8'h80);
		check(baud_locked, 1'b1);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			b = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : seed[7:0];
			if (b == 8'h00) b = 8'h7f;
			host.send_byte(b);
			check(rx_data, b);
		end
		check(8'(rx_pulses), 8'h08);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			n = host.rx_cnt;
			tx_data = (i == 0) ? 8'h55 : seed[15:8];
			tx_valid = 1'b1;
			while (tx_ready !== 1'b1) @(negedge clk_sys);
			@(negedge clk_sys);
			tx_valid = 1'b0;
			for (int k = 0; k < 20 * P && host.rx_cnt == n; k++) @(negedge clk_sys);
			check(host.rx_byte, tx_data);
		end
		watchdog_enable = 1'b1;
		idle_state = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(watchdog_refresh, 1'b1);
		check(clock_keep, 1'b1);
		check(periph_keep, 1'b1);
		directed_exec = 1'b1;
		repeat (2) @(negedge clk_sys);
		check(fetch_enable, 1'b1);
		directed_exec = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(fetch_enable, 1'b0);
		pulse(mode_bit_write);
		check(debug_mode_bit, 1'b0);
		check(fetch_enable, 1'b1);
		pulse(breakpoint_opcode);
		check(debug_mode_bit, 1'b0);
		break_enable = 1'b1;
		pulse(breakpoint_opcode);
		check(debug_mode_bit, 1'b1);
		check(idle_exit, 1'b1);
		for (int i = 0; i < 4; i++) begin
			pulse(breakpoint_opcode);
			case (i)
				0: pulse(por_reset);
				1: pulse(brownout_reset);
				2: pulse(watchdog_reset);
				default: pulse(reset_pin_low);
			endcase
			check(debug_mode_bit, 1'b0);
			check(fetch_enable, 1'b1);
		end
		pulse(breakpoint_opcode);
		deep_sleep_state = 1'b1;
		host.hold_low(3);
		repeat (6) @(negedge clk_sys);
		check(wake_seen, 1'b1);
		check(debug_mode_bit, 1'b0);
		// key bytes under the reset pin still pass the receiver
		deep_sleep_state = 1'b0;
		n = rx_pulses;
		reset_pin_low = 1'b1;
		host.send_unlock();
		reset_pin_low = 1'b0;
		check(8'(rx_pulses - n), 8'h05);
		check(rx_data, 8'hcd);
		check(debug_mode_bit, 1'b0);
		repeat (50 * P) @(negedge clk_sys);
		finish_test();
	end
endmodule // debug_mode_ctl_tb
`default_nettype wire
